// [logic/acr_pkg.sv]
// Summary of operation
// - sample RAM spans 0x20000 bytes, read/write
// - eight channel buffers at 0x4000-byte steps
// - 24-bit samples, MSB in bit 23
// - control registers clear after configuration load
// - bits 0-3 enable devices into standby
// - clearing enable halts device immediately
// - transfer needs enable AND start condition
// - bits 4-7 hold sample counters at zero
// - run starts device; master drives chain start
// - two-bit clock selects at bits 12-15
// - bits 18-19 route analog output
// - bits 20-21 route digital output
// - set then clear bit 23 clears interrupt
// - offset 0x04 configures sync chain behaviour
// - load range strobes only until configuration completes
// - slaves bits 0-3, masters 4-7; slaves wait
// - non-slave devices, masters too, run autonomously
package acr_pkg;
    // ****************************************
    // address spaces and offsets
    // ****************************************
    localparam logic [1:0] SPACE_RAM = 2'h1;
    localparam logic [1:0] SPACE_CTL = 2'h2;
    localparam logic [1:0] SPACE_LOAD = 2'h3;
    localparam int RAM_WORDS = 32768;
    localparam logic [17:0] RAM_BYTES = 18'h20000;
    localparam logic [16:0] BUF_STEP = 17'h04000;
    localparam logic [9:0] OFS_CONTROL = 10'h000;
    localparam logic [9:0] OFS_SYNC = 10'h004;
    localparam logic [9:0] OFS_RATE = 10'h008;
    localparam logic [9:0] OFS_EXTRA = 10'h018;
    localparam logic [9:0] OFS_BUFSIZE = 10'h01C;
    localparam logic [9:0] OFS_STATUS = 10'h010;
    localparam logic [8:0] OFS_SRC_SEL = 9'h000;
    localparam logic [8:0] OFS_IN_STATUS = 9'h000;
    // ****************************************
    // control fields
    // ****************************************
    localparam int CTL_EN_LSB = 0;
    localparam int CTL_CRST_LSB = 4;
    localparam int CTL_RUN_LSB = 8;
    localparam int CTL_ACLK_LSB = 12;
    localparam int CTL_DCLK_LSB = 14;
    localparam int CTL_AROUTE_LSB = 18;
    localparam int CTL_DROUTE_LSB = 20;
    localparam int CTL_FILT_BIT = 22;
    localparam int CTL_IRQCLR_BIT = 23;
    localparam logic [31:0] CTL_USED_MASK = 32'h00FCFFFF;
    localparam int SYNC_SLAVE_LSB = 0;
    localparam int SYNC_MASTER_LSB = 4;
    localparam logic [31:0] REG_RESET = 32'h00000000;
    localparam int SAMPLE_W = 24;
    localparam int CNT_W = 12;
    localparam int CAP_W = 26;
    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        ACR_ST_LOAD = 2'b01,
        ACR_ST_RUN = 2'b10
    } acr_phase_t;
    typedef enum logic [1:0] {
        ACR_CLK_NONE = 2'h0,
        ACR_CLK_INTERNAL = 2'h1,
        ACR_CLK_CHAIN = 2'h2,
        ACR_CLK_DIG_IN = 2'h3
    } acr_clk_sel_t;
endpackage

// [logic/acr_stream_if.sv]
`timescale 1ns/1ps
// valid/ready word stream between the block's own modules
interface acr_stream_if #(parameter int W = 26);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// [logic/acr_pair_buffer.sv]
`timescale 1ns/1ps
module acr_pair_buffer #(
    parameter int W = 26
) (
    input wire logic core_clk,
    input wire logic reset,
    acr_stream_if.snk in_s,
    acr_stream_if.src out_s
);
    typedef struct packed {
        logic [1:0] cnt;
        logic [W-1:0] ent0;
        logic [W-1:0] ent1;
        logic rdy;
    } acr_buf_state_t;

    acr_buf_state_t r_reg;
    acr_buf_state_t r_next;
    logic push;
    logic pop;
    logic [1:0] wi;

    // ****************************************
    // two-entry queue, ready straight from a flop
    // ****************************************
    assign in_s.ready = r_reg.rdy;
    assign out_s.valid = (r_reg.cnt != 2'h0);
    assign out_s.data = r_reg.ent0;

    // shift on pop, write at first free slot on push
    always_comb begin
        r_next = r_reg;
        push = in_s.valid & r_reg.rdy;
        pop = out_s.valid & out_s.ready;
        wi = r_reg.cnt - {1'b0, pop};
        if (pop) begin
            r_next.ent0 = r_reg.ent1;
        end
        if (push) begin
            if (wi == 2'h0) begin
                r_next.ent0 = in_s.data;
            end else begin
                r_next.ent1 = in_s.data;
            end
        end
        r_next.cnt = r_reg.cnt + {1'b0, push} - {1'b0, pop};
        r_next.rdy = (r_next.cnt != 2'h2);
    end

    // state register
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            r_reg <= '{cnt: 2'h0, ent0: '0, ent1: '0, rdy: 1'b1};
        end else begin
            r_reg <= r_next;
        end
    end

    a_buf_depth_bound: assert property (
        @(posedge core_clk) disable iff (reset) r_reg.cnt <= 2'h2)
        else $error("buffer holds more than two words");
    a_buf_full_stall: assert property (
        @(posedge core_clk) disable iff (reset)
        (r_reg.cnt == 2'h2) |-> !in_s.ready && out_s.valid)
        else $error("full buffer still offers ready");
endmodule

// [logic/acr_control_regs.sv]
`timescale 1ns/1ps
module acr_control_regs (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic host_req,
    input wire logic host_we,
    input wire logic [1:0] host_space,
    input wire logic [16:0] host_addr,
    input wire logic [31:0] host_wdata,
    output logic [31:0] host_rdata,
    output logic host_rvalid,
    input wire logic config_done,
    output logic load_valid,
    output logic [31:0] load_data,
    output logic [31:0] src_select,
    input wire logic [31:0] in_status,
    input wire logic [1:0] play_tick,
    output logic play_valid,
    output logic play_dev,
    output logic [23:0] play_left,
    output logic [23:0] play_right,
    input wire logic cap_valid,
    output logic cap_ready,
    input wire logic cap_dev,
    input wire logic cap_chan,
    input wire logic [23:0] cap_sample,
    input wire logic sync_start_in,
    output logic sync_start_out,
    output logic [3:0] dev_running,
    output logic [1:0] ana_clk_sel,
    output logic [1:0] dig_clk_sel,
    output logic [1:0] ana_route,
    output logic [1:0] dig_route,
    output logic filter_rate_high,
    input wire logic irq_event,
    output logic irq_pending,
    output logic [15:0] rate_value,
    output logic [31:0] extra_control,
    output logic [31:0] buffer_size
);
    typedef struct packed {
        acr_pkg::acr_phase_t st;
        logic [31:0] ctl;
        logic [7:0] sync;
        logic [15:0] rate;
        logic [31:0] extra;
        logic [31:0] bufsz;
        logic [31:0] src_sel;
        logic [3:0][11:0] cnt;
        logic [3:0] started;
        logic [3:0] running;
        logic [1:0] play_pend;
        logic irq;
        logic sync_out;
        logic [31:0] rdata;
        logic rvalid;
        logic load_valid;
        logic [31:0] load_data;
        logic play_valid;
        logic play_dev;
        logic [23:0] play_l;
        logic [23:0] play_r;
    } acr_state_t;

    acr_state_t r_reg;
    acr_state_t r_next;
    logic [23:0] ram [acr_pkg::RAM_WORDS];
    logic [9:0] ctl_ofs;
    logic [8:0] load_ofs;
    logic [14:0] widx;
    logic host_ram;
    logic host_ram_wr;
    logic irq_clr;
    logic play_serve;
    logic pd;
    logic [3:0] adv;
    logic [1:0] cdev;
    logic cap_wr;
    logic [14:0] cap_idx;
    logic [2:0] pbuf_l;
    logic [2:0] pbuf_r;

    acr_stream_if #(.W(acr_pkg::CAP_W)) cap_in_s ();
    acr_stream_if #(.W(acr_pkg::CAP_W)) cap_out_s ();

    // ****************************************
    // capture path buffer
    // ****************************************
    assign cap_in_s.valid = cap_valid;
    assign cap_in_s.data = {cap_dev, cap_chan, cap_sample};
    assign cap_ready = cap_in_s.ready;
    // host RAM access wins the port, so capture stalls here
    assign cap_out_s.ready = !host_ram;

    acr_pair_buffer #(.W(acr_pkg::CAP_W)) u_cap_buf (
        .core_clk(core_clk),
        .reset(reset),
        .in_s(cap_in_s),
        .out_s(cap_out_s)
    );

    // ****************************************
    // address split
    // ****************************************
    // low two address bits ignored, word access only
    assign ctl_ofs = {host_addr[9:2], 2'h0};
    assign load_ofs = {host_addr[8:2], 2'h0};
    // buffer number in bits 16:14, sample in 13:2
    assign widx = host_addr[16:2];
    assign host_ram = host_req && (host_space == acr_pkg::SPACE_RAM);
    assign host_ram_wr = host_ram && host_we;
    assign cdev = {cap_out_s.data[25], 1'b1};
    assign cap_idx = {cdev, cap_out_s.data[24], r_reg.cnt[cdev]};

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb begin
        r_next = r_reg;
        r_next.rvalid = 1'b0;
        r_next.load_valid = 1'b0;
        r_next.play_valid = 1'b0;
        adv = 4'h0;
        // configuration load phase, registers stay at zero
        if (r_reg.st == acr_pkg::ACR_ST_LOAD) begin
            if (host_req && host_we
                    && host_space == acr_pkg::SPACE_LOAD) begin
                r_next.load_valid = 1'b1;
                r_next.load_data = host_wdata;
            end
            if (config_done) begin
                r_next.st = acr_pkg::ACR_ST_RUN;
            end
        end else if (host_req && host_we) begin
            // write decode; unmapped offsets fall through
            if (host_space == acr_pkg::SPACE_CTL
                    && ctl_ofs == acr_pkg::OFS_CONTROL) begin
                r_next.ctl = host_wdata & acr_pkg::CTL_USED_MASK;
            end else if (host_space == acr_pkg::SPACE_CTL
                    && ctl_ofs == acr_pkg::OFS_SYNC) begin
                r_next.sync = host_wdata[7:0];
            end else if (host_space == acr_pkg::SPACE_CTL
                    && ctl_ofs == acr_pkg::OFS_RATE) begin
                r_next.rate = host_wdata[15:0];
            end else if (host_space == acr_pkg::SPACE_CTL
                    && ctl_ofs == acr_pkg::OFS_EXTRA) begin
                r_next.extra = host_wdata;
            end else if (host_space == acr_pkg::SPACE_CTL
                    && ctl_ofs == acr_pkg::OFS_BUFSIZE) begin
                r_next.bufsz = host_wdata;
            end else if (host_space == acr_pkg::SPACE_LOAD
                    && load_ofs == acr_pkg::OFS_SRC_SEL) begin
                r_next.src_sel = host_wdata;
            end
        end
        // read decode, one answer per read, zero when unmapped
        if (host_req && !host_we) begin
            r_next.rvalid = 1'b1;
            r_next.rdata = acr_pkg::REG_RESET;
            if (host_space == acr_pkg::SPACE_RAM) begin
                r_next.rdata = {8'h00, ram[widx]};
            end else if (host_space == acr_pkg::SPACE_CTL
                    && ctl_ofs == acr_pkg::OFS_STATUS) begin
                r_next.rdata = {22'h0, r_reg.irq, r_reg.running,
                    r_reg.sync_out, r_reg.play_pend, r_reg.started[1:0]};
            end else if (host_space == acr_pkg::SPACE_CTL
                    && ctl_ofs < acr_pkg::OFS_STATUS) begin
                r_next.rdata = {20'h00000, r_reg.cnt[ctl_ofs[3:2]]};
            end else if (host_space == acr_pkg::SPACE_LOAD
                    && r_reg.st == acr_pkg::ACR_ST_RUN
                    && load_ofs == acr_pkg::OFS_IN_STATUS) begin
                r_next.rdata = in_status;
            end
        end
        // interrupt: falling acknowledge bit clears, event wins
        irq_clr = r_reg.ctl[acr_pkg::CTL_IRQCLR_BIT]
            & ~r_next.ctl[acr_pkg::CTL_IRQCLR_BIT];
        r_next.irq = (r_reg.irq & ~irq_clr) | irq_event;
        // start conditions per device
        for (int d = 0; d < 4; d++) begin
            if (!r_next.ctl[acr_pkg::CTL_EN_LSB + d]) begin
                r_next.started[d] = 1'b0;
            end else if (sync_start_in) begin
                r_next.started[d] = 1'b1;
            end
            // enable AND (chain start for slaves, else run)
            r_next.running[d] = r_next.ctl[acr_pkg::CTL_EN_LSB + d]
                & (r_next.sync[acr_pkg::SYNC_SLAVE_LSB + d]
                ? r_next.started[d]
                : r_next.ctl[acr_pkg::CTL_RUN_LSB + d]);
        end
        // master devices put their run onto the chain
        r_next.sync_out = |(r_next.sync[7:4]
            & r_next.ctl[11:8] & r_next.ctl[3:0]);
        // playback: analog first, RAM port only when host idle
        play_serve = !host_ram && (r_reg.play_pend != 2'h0);
        pd = !r_reg.play_pend[0];
        pbuf_l = {pd, 2'b00};
        pbuf_r = {pd, 2'b01};
        if (play_serve) begin
            r_next.play_valid = 1'b1;
            r_next.play_dev = pd;
            r_next.play_l = ram[{pbuf_l, r_reg.cnt[{pd, 1'b0}]}];
            r_next.play_r = ram[{pbuf_r, r_reg.cnt[{pd, 1'b0}]}];
            adv[{pd, 1'b0}] = 1'b1;
        end
        for (int p = 0; p < 2; p++) begin
            r_next.play_pend[p] = ((r_reg.play_pend[p]
                & ~(play_serve && (pd == p[0]))) | play_tick[p])
                & r_next.running[2 * p];
        end
        // capture: word accepted only while device runs
        cap_wr = cap_out_s.valid && cap_out_s.ready
            && r_reg.running[cdev];
        if (cap_wr && cap_out_s.data[24]) begin
            adv[cdev] = 1'b1;
        end
        // sample counters, held at zero by counter reset
        for (int d = 0; d < 4; d++) begin
            if (r_next.ctl[acr_pkg::CTL_CRST_LSB + d]) begin
                r_next.cnt[d] = 12'h000;
            end else if (adv[d]) begin
                r_next.cnt[d] = r_reg.cnt[d] + 12'h001;
            end
        end
    end

    // ****************************************
    // state and sample storage
    // ****************************************
    // state register, load phase and all else zero after reset
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            r_reg <= '{st: acr_pkg::ACR_ST_LOAD, default: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    // sample RAM, host write has the port before capture
    always_ff @(posedge core_clk) begin
        if (host_ram_wr) begin
            ram[widx] <= host_wdata[23:0];
        end else if (cap_wr) begin
            ram[cap_idx] <= cap_out_s.data[23:0];
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign host_rdata = r_reg.rdata;
    assign host_rvalid = r_reg.rvalid;
    assign load_valid = r_reg.load_valid;
    assign load_data = r_reg.load_data;
    assign src_select = r_reg.src_sel;
    assign play_valid = r_reg.play_valid;
    assign play_dev = r_reg.play_dev;
    assign play_left = r_reg.play_l;
    assign play_right = r_reg.play_r;
    assign sync_start_out = r_reg.sync_out;
    assign dev_running = r_reg.running;
    // clock selects, routing and filter select
    assign ana_clk_sel = r_reg.ctl[acr_pkg::CTL_ACLK_LSB +: 2];
    assign dig_clk_sel = r_reg.ctl[acr_pkg::CTL_DCLK_LSB +: 2];
    assign ana_route = r_reg.ctl[acr_pkg::CTL_AROUTE_LSB +: 2];
    assign dig_route = r_reg.ctl[acr_pkg::CTL_DROUTE_LSB +: 2];
    assign filter_rate_high = r_reg.ctl[acr_pkg::CTL_FILT_BIT];
    assign irq_pending = r_reg.irq;
    assign rate_value = r_reg.rate;
    assign extra_control = r_reg.extra;
    assign buffer_size = r_reg.bufsz;

    // ****************************************
    // checks
    // ****************************************
    logic [3:0] cnt_nz;
    always_comb begin
        for (int d = 0; d < 4; d++) begin
            cnt_nz[d] = (r_reg.cnt[d] != 12'h000);
        end
    end

    sequence s_ack;
        r_reg.ctl[acr_pkg::CTL_IRQCLR_BIT]
            ##1 !r_reg.ctl[acr_pkg::CTL_IRQCLR_BIT];
    endsequence

    a_load_clears_regs: assert property (
        @(posedge core_clk) disable iff (reset)
        $rose(r_reg.st[1]) |-> r_reg.ctl == 32'h0 && r_reg.sync == 8'h0)
        else $error("registers not zero after configuration load");
    a_run_needs_enable: assert property (
        @(posedge core_clk) disable iff (reset)
        (r_reg.running & ~r_reg.ctl[3:0]) == 4'h0)
        else $error("device runs without enable");
    a_cnt_reset_hold: assert property (
        @(posedge core_clk) disable iff (reset)
        (r_reg.ctl[7:4] & $past(r_reg.ctl[7:4]) & cnt_nz) == 4'h0)
        else $error("counter not held at zero");
    a_irq_ack_clears: assert property (
        @(posedge core_clk) disable iff (reset)
        s_ack ##0 !$past(irq_event) |-> !irq_pending)
        else $error("interrupt not cleared by acknowledge");
    a_slave_waits_chain: assert property (
        @(posedge core_clk) disable iff (reset)
        ((r_reg.running & ~$past(r_reg.running) & r_reg.sync[3:0]
            & ~r_reg.started) == 4'h0)
        && ($past(sync_start_in)
            || ((r_reg.started & ~$past(r_reg.started)) == 4'h0)))
        else $error("slave started without chain start");
    a_master_chain_start: assert property (
        @(posedge core_clk) disable iff (reset)
        $rose(sync_start_out) |-> |(r_reg.sync[7:4] & r_reg.ctl[11:8]))
        else $error("chain start without master run");
    a_autonomous_run: assert property (
        @(posedge core_clk) disable iff (reset)
        ((r_reg.running ^ (r_reg.ctl[3:0] & r_reg.ctl[11:8]))
            & ~r_reg.sync[3:0]) == 4'h0)
        else $error("autonomous device ignores enable and run");
    a_unused_bits_zero: assert property (
        @(posedge core_clk) disable iff (reset)
        $past(host_req && host_we && host_space == acr_pkg::SPACE_CTL)
        |-> r_reg.ctl[17:16] == 2'h0)
        else $error("unused control bits stored");
    a_ram_read_width: assert property (
        @(posedge core_clk) disable iff (reset)
        $past(host_ram && !host_we) |-> host_rvalid
            && host_rdata[31:24] == 8'h00)
        else $error("RAM read answer wrong");

    // strobes only for running devices and the load phase
    a_play_needs_run: assert property (
        @(posedge core_clk) disable iff (reset)
        play_valid |-> (play_dev ? $past(dev_running[2])
            : $past(dev_running[0])))
        else $error("sample pair for stopped device");
    a_load_only_early: assert property (
        @(posedge core_clk) disable iff (reset)
        load_valid |-> $past(r_reg.st == acr_pkg::ACR_ST_LOAD))
        else $error("load strobe after configuration");
endmodule

// [verif/acr_host_model.sv]
`timescale 1ns/1ps
// ********************
// host bridge model: word accesses only
// ********************
module acr_host_model (
    input wire logic core_clk,
    input wire logic [31:0] host_rdata,
    input wire logic host_rvalid,
    output logic host_req,
    output logic host_we,
    output logic [1:0] host_space,
    output logic [16:0] host_addr,
    output logic [31:0] host_wdata
);
    // bus idle from time zero
    initial begin
        host_req = 1'h0;
        {host_we, host_space, host_addr, host_wdata} = '0;
    end
    // request held n cycles; address and data lines are scrambled on release
    task automatic issue(input logic we, input logic [1:0] sp,
            input logic [16:0] a, input logic [31:0] d, input int n);
        @(negedge core_clk);
        host_req = 1'h1;
        host_we = we;
        host_space = sp;
        host_addr = {a[16:2], 2'h0};
        host_wdata = d;
        repeat (n) @(negedge core_clk);
        host_req = 1'h0;
        host_addr = ~host_addr;
        host_wdata = ~host_wdata;
    endtask
    // write, then an idle cycle so its effect has landed
    task automatic wr(input logic [1:0] sp, input logic [16:0] a,
            input logic [31:0] d);
        issue(1'h1, sp, a, d, 1);
        @(negedge core_clk);
    endtask
    // read with a bounded wait for the answer
    task automatic rd(input logic [1:0] sp, input logic [16:0] a,
            output logic [31:0] d, output bit ok);
        ok = 1'h0;
        issue(1'h0, sp, a, 32'h0, 1);
        for (int i = 0; i < 8 && !ok; i++) begin
            if (host_rvalid === 1'h1) ok = 1'h1;
            else @(negedge core_clk);
        end
        d = host_rdata;
    endtask
endmodule

// [verif/audio_card_control_regs_test.sv]
`timescale 1ns/1ps
// compare two values, count and report a mismatch
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module audio_card_control_regs_test;
    logic core_clk = 1'h0;
    logic reset, config_done, cap_valid, cap_dev, cap_chan, cap_ready;
    logic sync_start_in, sync_start_out, irq_event, irq_pending;
    logic host_req, host_we, host_rvalid, load_valid, filter_rate_high;
    logic play_valid, play_dev;
    logic [1:0] play_tick, host_space, ana_clk_sel, dig_clk_sel;
    logic [1:0] ana_route, dig_route;
    logic [3:0] dev_running;
    logic [15:0] rate_value;
    logic [16:0] host_addr, wa [0:7];
    logic [23:0] cap_sample, play_left, play_right, smp [0:4];
    logic [31:0] host_wdata, host_rdata, load_data, src_select, in_status;
    logic [31:0] extra_control, buffer_size, v, wv [0:7];
    int error_cnt = 0;
    int cmp_count = 0;
    int load_cnt = 0;
    int seed = 32'h504DDA5D;
    bit saw_full, seen;
    // 200 MHz clock
    always #2.5 core_clk = ~core_clk;
    // count load strobes, note when capture refuses words
    always @(negedge core_clk) begin
        if (load_valid === 1'h1) load_cnt++;
        if (cap_ready === 1'h0) saw_full = 1'h1;
    end
    acr_control_regs DUT (
        .core_clk, .reset, .host_req, .host_we, .host_space, .host_addr,
        .host_wdata, .host_rdata, .host_rvalid, .config_done, .load_valid,
        .load_data, .src_select, .in_status, .play_tick, .play_valid,
        .play_dev, .play_left, .play_right, .cap_valid, .cap_ready,
        .cap_dev, .cap_chan, .cap_sample, .sync_start_in, .sync_start_out,
        .dev_running, .ana_clk_sel, .dig_clk_sel, .ana_route, .dig_route,
        .filter_rate_high, .irq_event, .irq_pending, .rate_value,
        .extra_control, .buffer_size
    );
    acr_host_model host (
        .core_clk, .host_rdata, .host_rvalid, .host_req, .host_we,
        .host_space, .host_addr, .host_wdata
    );
    // RAM keeps 24 sample bits, upper byte reads as zero
    function automatic logic [31:0] ram_word(input logic [23:0] s);
        return {8'h00, s};
    endfunction
    // read one word and compare it
    task automatic rdc(input logic [1:0] sp, input logic [16:0] a,
            input logic [31:0] e);
        logic [31:0] d;
        bit ok;
        host.rd(sp, a, d, ok);
        if (!ok) begin
            error_cnt++;
            finish_test();
        end
        `CHK(d, e)
    endtask
    // one play request, then a bounded wait for the pair
    task automatic tick_wait(input logic p, output bit s);
        s = 1'h0;
        @(negedge core_clk) play_tick[p] = 1'h1;
        @(negedge core_clk) play_tick = 2'h0;
        for (int i = 0; i < 16 && !s; i++) begin
            s = (play_valid === 1'h1);
            if (!s) @(negedge core_clk);
        end
    endtask
    // hand one capture word over once the buffer has room
    task automatic push(input logic ch, input logic [23:0] s);
        @(negedge core_clk);
        for (int i = 0; i < 40 && cap_ready !== 1'h1; i++)
            @(negedge core_clk);
        if (cap_ready !== 1'h1) begin
            error_cnt++;
            finish_test();
        end
        cap_valid = 1'h1;
        cap_chan = ch;
        cap_sample = s;
        @(negedge core_clk);
        cap_valid = 1'h0;
        cap_sample = ~s;
    endtask
    // closing report
    task automatic finish_test();
        $display("mismatches %0d of %0d compares", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ********************
    // main sequence
    // ********************
    initial begin
        {reset, config_done, cap_valid, cap_dev, cap_chan} = 5'h10;
        {sync_start_in, irq_event, play_tick, cap_sample} = '0;
        in_status = $random(seed);
        repeat (12) @(posedge core_clk);
        @(negedge core_clk) reset = 1'h0;
        `CHK({dev_running, ana_route, irq_pending, rate_value}, '0)
        `CHK(cap_ready, 1'h1)
        // load phase: only the load range is taken
        v = $random(seed);
        host.wr(2'h3, 17'h00040, v);
        host.wr(2'h2, 17'h00000, 32'h00003101);
        `CHK(load_data, v)
        `CHK({load_cnt, ana_clk_sel, dev_running}, {32'h1, 6'h0})
        @(negedge core_clk) config_done = 1'h1;
        @(negedge core_clk) config_done = 1'h0;
        host.wr(2'h3, 17'h00000, v);
        `CHK({src_select, load_cnt}, {v, 32'h1})
        rdc(2'h3, 17'h00000, in_status);
        // every clock-select and routing code, bits 16-17 set
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            host.wr(2'h2, 17'h0, {9'h0, v[0], i[1:0], ~i[1:0], 2'h3,
                i[1:0], ~i[1:0], 12'h0});
            `CHK({ana_clk_sel, dig_clk_sel}, {~i[1:0], i[1:0]})
            `CHK({ana_route, dig_route}, {~i[1:0], i[1:0]})
            `CHK(filter_rate_high, v[0])
        end
        host.wr(2'h2, 17'h0000C, 32'hFFFFFFFF);
        `CHK({ana_clk_sel, dig_route, rate_value}, {4'h3, 16'h0})
        rdc(2'h2, 17'h00014, 32'h0);
        v = $random(seed);
        host.wr(2'h2, 17'h00008, v);
        host.wr(2'h2, 17'h00018, ~v);
        host.wr(2'h2, 17'h0001C, {v[15:0], v[31:16]});
        `CHK({rate_value, extra_control}, {v[15:0], ~v})
        `CHK(buffer_size, {v[15:0], v[31:16]})
        // one word in each channel buffer, top word in the last
        for (int b = 0; b < 8; b++) begin
            v = $random(seed);
            wa[b] = {b[2:0], ((b == 7) ? 12'hFFF : v[11:0]), 2'h0};
            wv[b] = $random(seed);
            host.wr(2'h1, wa[b], wv[b]);
        end
        for (int b = 0; b < 8; b++) begin
            rdc(2'h1, wa[b], ram_word(wv[b][23:0]));
        end
        // playback: armed, running, counter held, disabled
        for (int k = 0; k < 5; k++) smp[k] = 24'($random(seed));
        host.wr(2'h1, 17'h00000, {8'hA5, smp[0]});
        host.wr(2'h1, 17'h04000, {8'h5A, smp[1]});
        host.wr(2'h2, 17'h0, 32'h00000001);
        `CHK(dev_running, 4'h0)
        host.wr(2'h2, 17'h0, 32'h00000101);
        `CHK(dev_running, 4'h1)
        tick_wait(1'h0, seen);
        `CHK({seen, play_dev}, 2'h2)
        `CHK({play_left, play_right}, {smp[0], smp[1]})
        rdc(2'h2, 17'h00000, 32'h1);
        host.wr(2'h2, 17'h0, 32'h00000111);
        tick_wait(1'h0, seen);
        rdc(2'h2, 17'h00000, 32'h0);
        host.wr(2'h2, 17'h0, 32'h00000100);
        tick_wait(1'h0, seen);
        `CHK({seen, dev_running}, 5'h0)
        // chain slave waits for a chain start; master drives one
        host.wr(2'h2, 17'h00004, 32'h00000002);
        host.wr(2'h2, 17'h0, 32'h00000202);
        `CHK(dev_running, 4'h0)
        @(negedge core_clk) sync_start_in = 1'h1;
        @(negedge core_clk) sync_start_in = 1'h0;
        @(negedge core_clk);
        `CHK(dev_running, 4'h2)
        host.wr(2'h2, 17'h00004, 32'h00000010);
        host.wr(2'h2, 17'h0, 32'h00000101);
        `CHK({sync_start_out, dev_running}, 5'h11)
        host.wr(2'h2, 17'h00004, 32'h0);
        // capture pairs land at the counter; a host stall loses none
        host.wr(2'h2, 17'h0, 32'h00000202);
        push(1'h0, smp[0]);
        push(1'h1, smp[1]);
        repeat (4) @(negedge core_clk);
        rdc(2'h2, 17'h00004, 32'h1);
        saw_full = 1'h0;
        fork
            host.issue(1'h0, 2'h1, 17'h0, 32'h0, 12);
            for (int k = 2; k < 5; k++) push(k[0], smp[k]);
        join
        repeat (4) @(negedge core_clk);
        `CHK({saw_full, cap_ready}, 2'h3)
        rdc(2'h1, 17'h08000, ram_word(smp[0]));
        rdc(2'h1, 17'h0C000, ram_word(smp[1]));
        rdc(2'h1, 17'h08004, ram_word(smp[2]));
        rdc(2'h1, 17'h0C004, ram_word(smp[3]));
        // pending interrupt clears on set-then-clear of bit 23
        @(negedge core_clk) irq_event = 1'h1;
        @(negedge core_clk) irq_event = 1'h0;
        @(negedge core_clk);
        `CHK(irq_pending, 1'h1)
        host.wr(2'h2, 17'h0, 32'h00800000);
        `CHK(irq_pending, 1'h1)
        host.wr(2'h2, 17'h0, 32'h0);
        `CHK(irq_pending, 1'h0)
        finish_test();
    end
endmodule
